// File: verilog/clkdiv_defines.svh
// register offsets, field positions, reset value and encodings of the clock divisor control block
`ifndef CLKDIV_DEFINES_SVH
`define CLKDIV_DEFINES_SVH

// register byte address (word aligned)
`define CLKDIV_CTRL_ADDR 4'h0
`define CLKDIV_STAT_ADDR 4'h4

// field positions of the control register
`define FLD_IRQ_RECOVERY 15
`define FLD_REDUCTION_HI 14
`define FLD_REDUCTION_LO 12
`define FLD_REDUCTION_EN 11
`define FLD_POSTSCALE_HI 10
`define FLD_POSTSCALE_LO 8
`define FLD_PLLOUT_HI 7
`define FLD_PLLOUT_LO 6
`define FLD_PLLIN_HI 4
`define FLD_PLLIN_LO 0

// reset value and writable bits (bit 5 is unimplemented)
`define CTRL_RESET 16'h3040
`define CTRL_WMASK 16'hffdf

// pll output divider reserved code
`define PLLOUT_RESERVED 2'h2

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/clkdiv_pkg.sv
// types shared by the clock divisor control block
package clkdiv_pkg;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_e;

    typedef struct packed {
        logic [15:0] ctrl;
        wr_state_e wr_state;
        logic aw_seen;
        logic [3:0] aw_addr;
        logic w_seen;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] reduce_cnt;
        logic cpu_tick;
        logic [7:0] rc_cnt;
        logic rc_tick;
        logic [7:0] cpu_ratio;
        logic [8:0] rc_ratio;
        logic [3:0] pll_out_ratio;
        logic [4:0] pll_in_code;
        logic reduction_on;
        logic aw_ready;
        logic w_ready;
        logic ar_ready;
    } state_s;

endpackage

// File: verilog/clock_divisor_cpu_clock_reduction_control.sv
// clock divisor control register with cpu clock reduction and axi4-lite slave
//
// How it works
// - with interrupt_recovery set, any interrupt clears reduction_enable so the cpu runs at full ratio.
// - with interrupt_recovery clear, interrupts leave reduction_enable untouched.
// - cpu_clock_reduction codes 111, 110, 101, 100 divide the instruction clock by 128, 64, 32, 16.
// - code 011 divides by 8 and is the reset value of the field.
// - code 001 divides by 2 while reduction is active.
// - rc_osc_postscale divides the rc oscillator by 2 to the power of its code, 1 to 128.
// - pll_output_divider code 11 divides by 8, 10 is reserved, 01 (the reset value) divides by 4 and 00 divides by 2.
`timescale 1ns/10ps
`default_nettype none
`include "clkdiv_defines.svh"

module clock_divisor_cpu_clock_reduction_control
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_event,
    output logic cpu_clk_tick,
    output logic rc_clk_tick,
    output logic [7:0] cpu_divide_ratio,
    output logic [8:0] rc_divide_ratio,
    output logic [3:0] pll_out_divide_ratio,
    output logic [4:0] pll_in_code,
    output logic reduction_active
);

    clkdiv_pkg::state_s cur_r;
    clkdiv_pkg::state_s cur_nxt;

    // ************************************************************
    // decode helpers
    // ************************************************************

    // reduction code to divisor; 000 and 010 are not printed, taken as 1 and 4
    function automatic logic [7:0] reduce_ratio(input logic [2:0] code);
        logic [7:0] r;
        r = 8'h01;
        case (code)
            3'h7: r = 8'h80;
            3'h6: r = 8'h40;
            3'h5: r = 8'h20;
            3'h4: r = 8'h10;
            3'h3: r = 8'h08;
            3'h2: r = 8'h04;
            3'h1: r = 8'h02;
            default: r = 8'h01;
        endcase
        return r;
    endfunction

    // pll output code to divisor; reserved code reports zero
    function automatic logic [3:0] pll_out_ratio(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h4;
        case (code)
            2'h3: r = 4'h8;
            `PLLOUT_RESERVED: r = 4'h0;
            2'h1: r = 4'h4;
            default: r = 4'h2;
        endcase
        return r;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************

    // bus handling, interrupt recovery and divider counters
    always_comb
    begin
        logic [15:0] wr_val;
        logic [15:0] merged;
        logic [2:0] red_code;
        logic [2:0] ps_code;
        logic [8:0] rc_ratio;
        logic do_write;
        wr_val = 16'h0000;
        merged = 16'h0000;
        red_code = 3'h0;
        ps_code = 3'h0;
        rc_ratio = 9'h001;
        do_write = 1'b0;
        cur_nxt = cur_r;

        // write address and data may arrive in either order
        if (s_axi_awvalid && cur_r.aw_ready)
        begin
            cur_nxt.aw_seen = 1'b1;
            cur_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur_r.w_ready)
        begin
            cur_nxt.w_seen = 1'b1;
            cur_nxt.w_data = s_axi_wdata;
            cur_nxt.w_strb = s_axi_wstrb;
        end

        case (cur_r.wr_state)
            clkdiv_pkg::WR_IDLE:
            begin
                if (cur_r.aw_seen && cur_r.w_seen)
                begin
                    cur_nxt.aw_seen = 1'b0;
                    cur_nxt.w_seen = 1'b0;
                    cur_nxt.bvalid = 1'b1;
                    cur_nxt.wr_state = clkdiv_pkg::WR_RESP;
                    if ({cur_r.aw_addr[3:2], 2'b00} == `CLKDIV_CTRL_ADDR)
                    begin
                        do_write = 1'b1;
                        cur_nxt.bresp = `RESP_OKAY;
                    end
                    else if ({cur_r.aw_addr[3:2], 2'b00} == `CLKDIV_STAT_ADDR)
                        cur_nxt.bresp = `RESP_OKAY; // read-only, write dropped
                    else
                        cur_nxt.bresp = `RESP_SLVERR;
                end
            end
            clkdiv_pkg::WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    cur_nxt.bvalid = 1'b0;
                    cur_nxt.wr_state = clkdiv_pkg::WR_IDLE;
                end
            end
            default: cur_nxt.wr_state = clkdiv_pkg::WR_IDLE;
        endcase

        // byte lanes merge into the register; bit 5 never stores
        wr_val[7:0] = cur_r.w_strb[0] ? cur_r.w_data[7:0] : cur_r.ctrl[7:0];
        wr_val[15:8] = cur_r.w_strb[1] ? cur_r.w_data[15:8] : cur_r.ctrl[15:8];
        merged = wr_val & `CTRL_WMASK;
        // reduction code only changes while reduction is off, as software expects
        if (cur_r.ctrl[`FLD_REDUCTION_EN])
            merged[`FLD_REDUCTION_HI:`FLD_REDUCTION_LO] = cur_r.ctrl[`FLD_REDUCTION_HI:`FLD_REDUCTION_LO];
        if (do_write)
            cur_nxt.ctrl = merged;

        // interrupt beats a same-cycle write of the enable bit
        if (irq_event && cur_nxt.ctrl[`FLD_IRQ_RECOVERY])
            cur_nxt.ctrl[`FLD_REDUCTION_EN] = 1'b0;

        // reads answer one cycle after the address is taken
        if (cur_r.rvalid)
        begin
            if (s_axi_rready)
                cur_nxt.rvalid = 1'b0;
        end
        else if (s_axi_arvalid && cur_r.ar_ready)
        begin
            cur_nxt.rvalid = 1'b1;
            cur_nxt.rresp = `RESP_OKAY;
            cur_nxt.rdata = 32'h0000_0000;
            if ({s_axi_araddr[3:2], 2'b00} == `CLKDIV_CTRL_ADDR)
                cur_nxt.rdata = {16'h0000, cur_r.ctrl};
            else if ({s_axi_araddr[3:2], 2'b00} == `CLKDIV_STAT_ADDR)
                cur_nxt.rdata = {16'h0000, cur_r.cpu_ratio, 7'h00, cur_r.reduction_on};
            else
                cur_nxt.rresp = `RESP_SLVERR;
        end

        // readies are registered and drop while a half or an answer is pending, so nothing is lost
        cur_nxt.aw_ready = !cur_nxt.aw_seen && cur_nxt.wr_state == clkdiv_pkg::WR_IDLE;
        cur_nxt.w_ready = !cur_nxt.w_seen && cur_nxt.wr_state == clkdiv_pkg::WR_IDLE;
        cur_nxt.ar_ready = !cur_nxt.rvalid;

        // cpu divider: full rate when reduction is off
        red_code = cur_r.ctrl[`FLD_REDUCTION_HI:`FLD_REDUCTION_LO];
        cur_nxt.reduction_on = cur_r.ctrl[`FLD_REDUCTION_EN];
        cur_nxt.cpu_ratio = cur_r.ctrl[`FLD_REDUCTION_EN] ? reduce_ratio(red_code) : 8'h01;
        if ({1'b0, cur_r.reduce_cnt} + 8'h01 >= cur_r.cpu_ratio)
        begin
            cur_nxt.reduce_cnt = 7'h00;
            cur_nxt.cpu_tick = 1'b1;
        end
        else
        begin
            cur_nxt.reduce_cnt = cur_r.reduce_cnt + 7'h01;
            cur_nxt.cpu_tick = 1'b0;
        end

        // rc postscaler: divide by two to the power of the code
        ps_code = cur_r.ctrl[`FLD_POSTSCALE_HI:`FLD_POSTSCALE_LO];
        rc_ratio = 9'h001 << ps_code;
        cur_nxt.rc_ratio = rc_ratio;
        if ({1'b0, cur_r.rc_cnt} + 9'h001 >= rc_ratio)
        begin
            cur_nxt.rc_cnt = 8'h00;
            cur_nxt.rc_tick = 1'b1;
        end
        else
        begin
            cur_nxt.rc_cnt = cur_r.rc_cnt + 8'h01;
            cur_nxt.rc_tick = 1'b0;
        end

        // pll divider settings handed to the pll
        cur_nxt.pll_out_ratio = pll_out_ratio(cur_r.ctrl[`FLD_PLLOUT_HI:`FLD_PLLOUT_LO]);
        cur_nxt.pll_in_code = cur_r.ctrl[`FLD_PLLIN_HI:`FLD_PLLIN_LO];
    end

    // ************************************************************
    // state register
    // ************************************************************

    // synchronous reset to documented power-on value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_r <= '0;
            cur_r.ctrl <= `CTRL_RESET;
            cur_r.cpu_ratio <= 8'h01;
            cur_r.rc_ratio <= 9'h001;
            cur_r.pll_out_ratio <= 4'h4;
            cur_r.wr_state <= clkdiv_pkg::WR_IDLE;
        end
        else
            cur_r <= cur_nxt;
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // every output is a field of the state register
    assign s_axi_awready = cur_r.aw_ready;
    assign s_axi_wready = cur_r.w_ready;
    assign s_axi_arready = cur_r.ar_ready;
    assign s_axi_bvalid = cur_r.bvalid;
    assign s_axi_bresp = cur_r.bresp;
    assign s_axi_rvalid = cur_r.rvalid;
    assign s_axi_rdata = cur_r.rdata;
    assign s_axi_rresp = cur_r.rresp;
    assign cpu_clk_tick = cur_r.cpu_tick;
    assign rc_clk_tick = cur_r.rc_tick;
    assign cpu_divide_ratio = cur_r.cpu_ratio;
    assign rc_divide_ratio = cur_r.rc_ratio;
    assign pll_out_divide_ratio = cur_r.pll_out_ratio;
    assign pll_in_code = cur_r.pll_in_code;
    assign reduction_active = cur_r.reduction_on;

endmodule
`default_nettype wire

// File: verif/clkdiv_asserts.sv
// concurrent checks on the ports of the clock divisor control block
`timescale 1ns/10ps
`default_nettype none
module clkdiv_asserts
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic cpu_clk_tick,
    input wire logic rc_clk_tick,
    input wire logic [7:0] cpu_divide_ratio,
    input wire logic [8:0] rc_divide_ratio,
    input wire logic [3:0] pll_out_divide_ratio,
    input wire logic reduction_active
);
    // ****************************************************************
    // bus timing and divider relations
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves offered together with no answer pending (readies not checked)
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    sequence b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_cpu_ratio_pow: assert property ($onehot(cpu_divide_ratio)) else $error("cpu ratio not a power of two");
    a_rc_ratio_pow: assert property ($onehot(rc_divide_ratio)) else $error("rc ratio not a power of two");
    a_pll_out_code: assert property ($onehot0(pll_out_divide_ratio) && !pll_out_divide_ratio[0])
        else $error("pll output ratio illegal");
    a_reset_values: assert property ($rose(aresetn) |-> cpu_divide_ratio == 8'h01
        && rc_divide_ratio == 9'h001 && pll_out_divide_ratio == 4'h4 && !reduction_active)
        else $error("ratios wrong after reset");
    a_off_full_ratio: assert property (!reduction_active [*2] |-> cpu_divide_ratio == 8'h01)
        else $error("ratio not one while reduction off");
    a_cpu_tick_full: assert property (cpu_divide_ratio == 8'h01 [*3] |-> cpu_clk_tick)
        else $error("cpu tick missing at ratio one");
    a_rc_tick_full: assert property (rc_divide_ratio == 9'h001 [*3] |-> rc_clk_tick)
        else $error("rc tick missing at ratio one");
    a_write_answer: assert property (wr_take |=> b_answer) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read data late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind clock_divisor_cpu_clock_reduction_control clkdiv_asserts chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .cpu_clk_tick(cpu_clk_tick), .rc_clk_tick(rc_clk_tick), .cpu_divide_ratio(cpu_divide_ratio),
    .rc_divide_ratio(rc_divide_ratio), .pll_out_divide_ratio(pll_out_divide_ratio),
    .reduction_active(reduction_active));
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the clock divisor control block
`timescale 1ns/10ps
`default_nettype none
`include "clkdiv_defines.svh"
module tb_top;
    // ****************************************************************
    // stimulus, bus tasks and scenarios
    // ****************************************************************
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, irq = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rd_q;
    logic awready, wready, bvalid, arready, rvalid, ctick, rtick, ract;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] cratio;
    logic [8:0] rratio;
    logic [3:0] pratio;
    logic [4:0] pin;
    int miscompares = 0, num_checks = 0;
    always #20 aclk = ~aclk;
    clock_divisor_cpu_clock_reduction_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_event(irq), .cpu_clk_tick(ctick), .rc_clk_tick(rtick), .cpu_divide_ratio(cratio),
        .rc_divide_ratio(rratio), .pll_out_divide_ratio(pratio), .pll_in_code(pin), .reduction_active(ract));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once taken
    task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // rready offered with the address and held until the answer is sampled
    task rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task pulse_irq();
        @(posedge aclk);
        irq <= 1'b1;
        @(posedge aclk);
        irq <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task t_reset();
        rd(`CLKDIV_CTRL_ADDR, rd_q, `RESP_OKAY);
        chk(rd_q, 32'h0000_3040);
        chk({cratio, rratio, pratio}, {8'h01, 9'h001, 4'h4});
    endtask
    task t_bit5();
        wr(`CLKDIV_CTRL_ADDR, 16'h0020, `RESP_OKAY);
        rd(`CLKDIV_CTRL_ADDR, rd_q, `RESP_OKAY);
        chk(rd_q, 32'h0000_0000);
        chk({28'h0, pratio}, 32'h0000_0002);
    endtask
    // every code of the three divider fields, plus the input divider pass-through
    task t_fields();
        logic [15:0] v;
        logic [3:0] pll_tab [4];
        pll_tab = '{4'h2, 4'h4, 4'h0, 4'h8};
        for (int i = 0; i < 8; i++)
        begin
            v = {1'b0, i[2:0], 1'b0, i[2:0], i[1:0], 3'b000, i[2:0]};
            wr(`CLKDIV_CTRL_ADDR, v, `RESP_OKAY);
            wr(`CLKDIV_CTRL_ADDR, v | 16'h0800, `RESP_OKAY);
            wr(`CLKDIV_CTRL_ADDR, v ^ 16'h7800 | 16'h0800, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk({24'h0, cratio}, 32'h1 << i);
            chk({23'h0, rratio}, 32'h1 << i);
            chk({28'h0, pratio}, {28'h0, pll_tab[i[1:0]]});
            chk({27'h0, pin}, i);
            rd(`CLKDIV_CTRL_ADDR, rd_q, `RESP_OKAY);
            chk(rd_q, {16'h0, v | 16'h0800});
            wr(`CLKDIV_CTRL_ADDR, v, `RESP_OKAY);
        end
    endtask
    // cpu at ratio 8 and rc postscaler at ratio 4 counted over one window
    task t_tick();
        int cnt;
        int rcnt;
        cnt = 0;
        rcnt = 0;
        wr(`CLKDIV_CTRL_ADDR, 16'h3000, `RESP_OKAY);
        wr(`CLKDIV_CTRL_ADDR, 16'h3a00, `RESP_OKAY);
        repeat (4) @(posedge aclk);
        repeat (64)
        begin
            @(posedge aclk);
            cnt += ctick;
            rcnt += rtick;
        end
        chk(cnt, 32'h0000_0008);
        chk(rcnt, 32'h0000_0010);
    endtask
    task t_irq();
        wr(`CLKDIV_CTRL_ADDR, 16'hb800, `RESP_OKAY);
        pulse_irq();
        rd(`CLKDIV_CTRL_ADDR, rd_q, `RESP_OKAY);
        chk(rd_q, 32'h0000_b000);
        chk({24'h0, cratio}, 32'h0000_0001);
        wr(`CLKDIV_CTRL_ADDR, 16'h3800, `RESP_OKAY);
        pulse_irq();
        rd(`CLKDIV_CTRL_ADDR, rd_q, `RESP_OKAY);
        chk(rd_q, 32'h0000_3800);
    endtask
    // status word and an unmapped address
    task t_map();
        rd(`CLKDIV_STAT_ADDR, rd_q, `RESP_OKAY);
        chk(rd_q, 32'h0000_0801);
        rd(4'h8, rd_q, `RESP_SLVERR);
        wr(4'h8, 16'h0000, `RESP_SLVERR);
    endtask
    task summarize();
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bit5();
        t_fields();
        t_tick();
        t_irq();
        t_map();
        summarize();
    end
    // watchdog well beyond the few hundred cycles the scenarios need
    initial
    begin
        #2_000_000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
